// [tsspi_pkg.sv]
package tsspi_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS      = 10;
    localparam int T_PWR_FLOAT_MS     = 20;
    localparam int T_SLEEP_ENTRY_US   = 35;
    localparam int T_WAKE_BURST_US    = 920;
    localparam int T_WAKE_FLOAT_US    = 400;
    localparam int T_SS_PULSE_NS      = 250;
    localparam int T_DUMMY_MIN_US     = 10;
    localparam int T_DUMMY_BURST_MS   = 1;
    localparam int T_SS_TIMEOUT_MS    = 1000;
    localparam int FREERUN_HZ         = 17;

    // longest times round down, least times round up
    localparam int PWR_FLOAT_CYC   = T_PWR_FLOAT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SLEEP_ENTRY_CYC = T_SLEEP_ENTRY_US * 1000 / CLK_PERIOD_NS;
    localparam int WAKE_BURST_CYC  = T_WAKE_BURST_US * 1000 / CLK_PERIOD_NS;
    localparam int WAKE_FLOAT_CYC  = (T_WAKE_FLOAT_US * 1000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int SS_PULSE_CYC    = T_SS_PULSE_NS / CLK_PERIOD_NS;
    localparam int DUMMY_MIN_CYC   = (T_DUMMY_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                                     / CLK_PERIOD_NS;
    localparam int DUMMY_BURST_CYC = T_DUMMY_BURST_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SS_TIMEOUT_CYC  = T_SS_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int FREERUN_CYC     = 1000000000 / (CLK_PERIOD_NS * FREERUN_HZ);

    // ****************************************************************
    // commands and counts
    // ****************************************************************
    localparam logic [7:0] CMD_NULL      = 8'h00;
    localparam logic [7:0] CMD_CAL       = 8'h01;
    localparam logic [7:0] CMD_END_CAL   = 8'h02;
    localparam logic [7:0] CMD_DRIFT     = 8'h03;
    localparam logic [1:0] CMD_PROX_PFX  = 2'h1;
    localparam logic [1:0] CMD_TOUCH_PFX = 2'h2;
    localparam logic [4:0] CAL_BURSTS    = 5'h0a;
    localparam logic [4:0] END_BURSTS    = 5'h14;
    localparam logic [3:0] DRIFT_CMDS    = 4'ha;
    localparam logic [5:0] THR_DEFAULT   = 6'h0a;
    localparam logic [3:0] BYTE_BITS     = 4'h8;
    localparam int         HYST_SHIFT    = 3;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [6:0] {
        ST_PWR_FLOAT = 7'h01,
        ST_IDLE      = 7'h02,
        ST_POST_CMD  = 7'h04,
        ST_SLEEP     = 7'h08,
        ST_WAKE      = 7'h10,
        ST_ARM       = 7'h20,
        ST_BURST     = 7'h40
    } tsspi_state_type;

    typedef struct packed {
        logic       touch;
        logic [6:0] position;
        logic       pol_err;
        logic       prox;
    } tsspi_acq_type;

    typedef struct packed {
        logic [5:0] prox_thr;
        logic [7:0] touch_thr;
        logic [7:0] touch_hyst;
        logic       end_cal_en;
    } tsspi_cfg_type;

    typedef struct packed {
        tsspi_state_type state;
        logic [31:0]     tmr;
        logic [4:0]      left;
        logic            pend_cal;
        logic            pend_end;
        logic            frame_ok;
        logic            ss_s1;
        logic            ss_s2;
        logic            ss_q;
        logic            done_s1;
        logic            done_s2;
        logic            done_q;
        logic [7:0]      resp;
        tsspi_cfg_type   cfg;
        logic [3:0]      drift_cnt;
        logic            drift_step;
        logic            burst_start;
        logic            data_ready_out;
        logic            data_ready_out_oe_n;
        logic            flag_oe_n;
        logic            ss_oe_n;
        logic            touch_flag;
        logic            near_flag;
    } tsspi_sys_type;

endpackage

// [tsspi_slider_port.sv]
`timescale 1ns/100ps

module tsspi_slider_port #(
    parameter int P_PWR_FLOAT   = tsspi_pkg::PWR_FLOAT_CYC,
    parameter int P_WAKE_BURST  = tsspi_pkg::WAKE_BURST_CYC,
    parameter int P_WAKE_FLOAT  = tsspi_pkg::WAKE_FLOAT_CYC,
    parameter int P_DUMMY_BURST = tsspi_pkg::DUMMY_BURST_CYC,
    parameter int P_SS_TIMEOUT  = tsspi_pkg::SS_TIMEOUT_CYC,
    parameter int P_FREERUN     = tsspi_pkg::FREERUN_CYC
) (
    // system
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    // serial link pins
    input  wire logic                     sclk_i,
    input  wire logic                     ss_n_i,
    output logic                          ss_n_o,
    output logic                          ss_n_oe_n_o,
    input  wire logic                     mosi_i,
    output logic                          miso_o,
    output logic                          miso_oe_n_o,
    // handshake and flag pins
    output logic                          data_ready_out_o,
    output logic                          data_ready_oe_n_o,
    output logic                          touch_flag_pin_o,
    output logic                          near_flag_pin_o,
    output logic                          flags_oe_n_o,
    // acquisition core
    output logic                          burst_start_o,
    input  wire logic                     burst_done_i,
    input  wire tsspi_pkg::tsspi_acq_type acq_i,
    output tsspi_pkg::tsspi_cfg_type      cfg_o,
    output logic                          drift_step_o
);

    // ****************************************************************
    // link domain
    // ****************************************************************
    tsspi_pkg::tsspi_sys_type s_r;
    tsspi_pkg::tsspi_sys_type s_nxt;

    // select high clears the frame, so no clock edge is needed after it
    logic [3:0] rx_cnt_r;
    logic [6:0] rx_sh_r;
    logic [7:0] rx_byte_r;
    logic       rx_done_r;
    logic [3:0] tx_cnt_r;
    logic       miso_r;
    logic       miso_oe_n_r;

    always_ff @(posedge sclk_i or posedge ss_n_i) begin
        if (ss_n_i) begin
            rx_cnt_r  <= 4'h0;
            rx_sh_r   <= 7'h00;
            rx_byte_r <= 8'h00;
            rx_done_r <= 1'b0;
        end else if (rx_cnt_r != tsspi_pkg::BYTE_BITS) begin
            rx_sh_r  <= {rx_sh_r[5:0], mosi_i};
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == tsspi_pkg::BYTE_BITS - 4'h1) begin
                rx_byte_r <= {rx_sh_r, mosi_i};
                rx_done_r <= 1'b1;
            end
        end
    end

    // response is only rewritten while select is high, so it is still here
    always_ff @(negedge sclk_i or posedge ss_n_i) begin
        if (ss_n_i) begin
            tx_cnt_r    <= 4'h0;
            miso_r      <= 1'b0;
            miso_oe_n_r <= 1'b1;
        end else if (tx_cnt_r != tsspi_pkg::BYTE_BITS) begin
            miso_r      <= s_r.resp[3'h7 - tx_cnt_r[2:0]];
            miso_oe_n_r <= 1'b0;
            tx_cnt_r    <= tx_cnt_r + 4'h1;
        end
    end

    // ****************************************************************
    // system domain
    // ****************************************************************
    logic                     ss_rise;
    logic                     ss_fall;
    logic                     byte_ev;
    logic                     cmd_ok;
    logic [7:0]               cmd;

    function automatic logic elapsed(input logic [31:0] t, input int n);
        elapsed = (t >= 32'(n - 1));
    endfunction

    function automatic logic [7:0] resp_of(input tsspi_pkg::tsspi_acq_type a);
        if (a.touch) begin
            resp_of = {1'b1, a.position};
        end else begin
            resp_of = {6'h00, a.pol_err, a.prox};
        end
    endfunction

    assign ss_rise = s_r.ss_s2 && !s_r.ss_q;
    assign ss_fall = !s_r.ss_s2 && s_r.ss_q;
    assign byte_ev = s_r.done_s2 && !s_r.done_q;
    assign cmd     = rx_byte_r;
    assign cmd_ok  = byte_ev && s_r.frame_ok && (s_r.state == tsspi_pkg::ST_IDLE);

    always_comb begin
        s_nxt             = s_r;
        s_nxt.ss_s1       = ss_n_i;
        s_nxt.ss_s2       = s_r.ss_s1;
        s_nxt.ss_q        = s_r.ss_s2;
        s_nxt.done_s1     = rx_done_r;
        s_nxt.done_s2     = s_r.done_s1;
        s_nxt.done_q      = s_r.done_s2;
        s_nxt.tmr         = s_r.tmr + 32'h1;
        s_nxt.burst_start = 1'b0;
        s_nxt.drift_step  = 1'b0;
        s_nxt.touch_flag  = acq_i.touch;
        s_nxt.near_flag   = acq_i.prox;
        if (ss_fall) begin
            s_nxt.frame_ok = s_r.data_ready_out && !s_r.data_ready_out_oe_n;
        end

        // commands take effect at the end of their byte
        if (cmd_ok) begin
            if (cmd[7:6] == tsspi_pkg::CMD_PROX_PFX) begin
                s_nxt.cfg.prox_thr = cmd[5:0];
            end else if (cmd[7:6] == tsspi_pkg::CMD_TOUCH_PFX) begin
                s_nxt.cfg.touch_thr  = {cmd[5:0], 2'h0};
                s_nxt.cfg.touch_hyst = 8'({cmd[5:0], 2'h0} >> tsspi_pkg::HYST_SHIFT);
            end else if (cmd == tsspi_pkg::CMD_CAL) begin
                s_nxt.pend_cal       = 1'b1;
                s_nxt.pend_end       = 1'b0;
                s_nxt.cfg.end_cal_en = 1'b0;
            end else if (cmd == tsspi_pkg::CMD_END_CAL) begin
                s_nxt.pend_end       = 1'b1;
                s_nxt.cfg.end_cal_en = 1'b1;
            end else if (cmd == tsspi_pkg::CMD_DRIFT && !s_r.resp[7]) begin
                if (s_r.drift_cnt == tsspi_pkg::DRIFT_CMDS - 4'h1) begin
                    s_nxt.drift_cnt  = 4'h0;
                    s_nxt.drift_step = 1'b1;
                end else begin
                    s_nxt.drift_cnt = s_r.drift_cnt + 4'h1;
                end
            end
            // null and unknown codes change nothing
        end

        unique case (s_r.state)
            tsspi_pkg::ST_PWR_FLOAT: begin
                if (elapsed(s_r.tmr, P_PWR_FLOAT)) begin
                    s_nxt.state       = tsspi_pkg::ST_BURST;
                    s_nxt.left        = tsspi_pkg::CAL_BURSTS;
                    s_nxt.burst_start = 1'b1;
                    s_nxt.data_ready_out        = 1'b0;
                    s_nxt.data_ready_out_oe_n   = 1'b0;
                    s_nxt.flag_oe_n   = 1'b0;
                end
            end
            tsspi_pkg::ST_IDLE: begin
                if (ss_fall) begin
                    s_nxt.tmr = 32'h0;
                end
                if (cmd_ok) begin
                    s_nxt.state = tsspi_pkg::ST_POST_CMD;
                    s_nxt.tmr   = 32'h0;
                end else if (ss_rise) begin
                    s_nxt.tmr = 32'h0;
                    if (elapsed(s_r.tmr, tsspi_pkg::DUMMY_MIN_CYC)) begin
                        s_nxt.state = tsspi_pkg::ST_ARM;
                        s_nxt.data_ready_out  = 1'b0;
                    end
                end else if (s_r.ss_s2 && elapsed(s_r.tmr, P_FREERUN)) begin
                    s_nxt.state       = tsspi_pkg::ST_BURST;
                    s_nxt.left        = 5'h1;
                    s_nxt.burst_start = 1'b1;
                    s_nxt.data_ready_out        = 1'b0;
                end
            end
            tsspi_pkg::ST_POST_CMD: begin
                if (ss_rise || elapsed(s_r.tmr, tsspi_pkg::SLEEP_ENTRY_CYC)) begin
                    s_nxt.state = tsspi_pkg::ST_SLEEP;
                    s_nxt.data_ready_out  = 1'b0;
                    s_nxt.tmr   = 32'h0;
                end
            end
            tsspi_pkg::ST_SLEEP: begin
                if (ss_rise || elapsed(s_r.tmr, P_SS_TIMEOUT)) begin
                    s_nxt.state     = tsspi_pkg::ST_WAKE;
                    s_nxt.tmr       = 32'h0;
                    s_nxt.ss_oe_n   = 1'b0;
                    s_nxt.data_ready_out_oe_n = 1'b1;
                    s_nxt.flag_oe_n = 1'b1;
                    if (!ss_rise) begin
                        s_nxt.pend_cal       = 1'b1;
                        s_nxt.pend_end       = 1'b0;
                        s_nxt.cfg.end_cal_en = 1'b0;
                    end
                end
            end
            tsspi_pkg::ST_WAKE: begin
                if (elapsed(s_r.tmr, tsspi_pkg::SS_PULSE_CYC)) begin
                    s_nxt.ss_oe_n = 1'b1;
                end
                if (elapsed(s_r.tmr, P_WAKE_FLOAT)) begin
                    s_nxt.data_ready_out_oe_n = 1'b0;
                    s_nxt.flag_oe_n = 1'b0;
                end
                if (elapsed(s_r.tmr, P_WAKE_BURST)) begin
                    s_nxt.state       = tsspi_pkg::ST_BURST;
                    s_nxt.burst_start = 1'b1;
                    s_nxt.pend_cal    = 1'b0;
                    s_nxt.pend_end    = 1'b0;
                    s_nxt.left        = s_r.pend_end ? tsspi_pkg::END_BURSTS :
                                        s_r.pend_cal ? tsspi_pkg::CAL_BURSTS : 5'h1;
                end
            end
            tsspi_pkg::ST_ARM: begin
                if (elapsed(s_r.tmr, P_DUMMY_BURST)) begin
                    s_nxt.state       = tsspi_pkg::ST_BURST;
                    s_nxt.left        = 5'h1;
                    s_nxt.burst_start = 1'b1;
                end
            end
            tsspi_pkg::ST_BURST: begin
                if (burst_done_i) begin
                    s_nxt.resp = resp_of(acq_i);
                    s_nxt.left = s_r.left - 5'h1;
                    if (s_r.left == 5'h1) begin
                        s_nxt.state = tsspi_pkg::ST_IDLE;
                        s_nxt.data_ready_out  = 1'b1;
                        s_nxt.tmr   = 32'h0;
                    end else begin
                        s_nxt.burst_start = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_r                <= '0;
            s_r.state          <= tsspi_pkg::ST_PWR_FLOAT;
            s_r.ss_s1          <= 1'b1;
            s_r.ss_s2          <= 1'b1;
            s_r.ss_q           <= 1'b1;
            s_r.cfg.prox_thr   <= tsspi_pkg::THR_DEFAULT;
            s_r.cfg.touch_thr  <= {tsspi_pkg::THR_DEFAULT, 2'h0};
            s_r.cfg.touch_hyst <= 8'({tsspi_pkg::THR_DEFAULT, 2'h0} >> tsspi_pkg::HYST_SHIFT);
            s_r.data_ready_out_oe_n      <= 1'b1;
            s_r.flag_oe_n      <= 1'b1;
            s_r.ss_oe_n        <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign ss_n_o            = 1'b0;
    assign ss_n_oe_n_o       = s_r.ss_oe_n;
    assign miso_o            = miso_r;
    assign miso_oe_n_o       = miso_oe_n_r;
    assign data_ready_out_o  = s_r.data_ready_out;
    assign data_ready_oe_n_o = s_r.data_ready_out_oe_n;
    assign touch_flag_pin_o  = s_r.touch_flag;
    assign near_flag_pin_o   = s_r.near_flag;
    assign flags_oe_n_o      = s_r.flag_oe_n;
    assign burst_start_o     = s_r.burst_start;
    assign cfg_o             = s_r.cfg;
    assign drift_step_o      = s_r.drift_step;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // cycles spent waiting for sleep after a command
    logic [31:0] post_cyc_r;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            post_cyc_r <= 32'h0;
        end else if (s_r.state == tsspi_pkg::ST_POST_CMD) begin
            post_cyc_r <= post_cyc_r + 32'h1;
        end else begin
            post_cyc_r <= 32'h0;
        end
    end

    a_busy_cmd_ignored: assert property (
        (byte_ev && s_r.state != tsspi_pkg::ST_IDLE) |=> $stable(s_r.cfg))
        else $error("command taken while busy");
    a_prox_thr_set: assert property (
        (cmd_ok && cmd[7:6] == 2'h1) |=> (cfg_o.prox_thr == $past(cmd[5:0])))
        else $error("proximity threshold not loaded");
    a_touch_thr_set: assert property (
        (cmd_ok && cmd[7:6] == 2'h2) |=> (cfg_o.touch_thr == {$past(cmd[5:0]), 2'h0}))
        else $error("touch threshold not scaled");
    a_cal_clears_end: assert property (
        (cmd_ok && cmd == 8'h01) |=> !cfg_o.end_cal_en)
        else $error("end calibration survived calibrate");
    a_resp_touch: assert property (
        (s_r.state == tsspi_pkg::ST_BURST && burst_done_i && acq_i.touch)
        |=> (s_r.resp == {1'b1, $past(acq_i.position)}))
        else $error("touch response wrong");
    a_resp_no_touch: assert property (
        (s_r.state == tsspi_pkg::ST_BURST && burst_done_i && !acq_i.touch)
        |=> (s_r.resp[7:2] == 6'h00 && s_r.resp[0] == $past(acq_i.prox)))
        else $error("idle response wrong");
    a_sleep_data_ready_out_low: assert property (
        (post_cyc_r == 32'(tsspi_pkg::SLEEP_ENTRY_CYC)) |-> !data_ready_out_o)
        else $error("sleep not entered in time");
    a_wake_ss_pulse: assert property (
        $fell(ss_n_oe_n_o) |-> (!ss_n_oe_n_o)[*8] ##18 ss_n_oe_n_o)
        else $error("wake pulse length wrong");
    a_burst_single: assert property (
        burst_start_o |=> !burst_start_o)
        else $error("burst start longer than one cycle");
    a_drift_cause: assert property (
        drift_step_o |-> $past(cmd_ok && cmd == 8'h03 && !s_r.resp[7]))
        else $error("drift step without drift command");

endmodule

// [tsspi_host_model.sv]
`timescale 1ns/100ps

module tsspi_host_model (
    // serial link
    output logic      sclk_o,
    output logic      ss_n_o,
    output logic      mosi_o,
    input  wire logic miso_i,
    input  wire logic miso_oe_n_i,
    // handshake
    input  wire logic data_ready_out_i,
    input  wire logic data_ready_out_oe_n_i
);
    initial begin
        sclk_o = 1'b1;
        ss_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // ****************************************************************
    // one framed byte, link clock runs only inside the frame
    // ****************************************************************
    task automatic xfer(input logic [7:0] cmd, output logic [7:0] rsp, output logic slept);
        #37;
        ss_n_o = 1'b0;
        #1000;
        for (int k = 7; k >= 0; k--) begin
            sclk_o = 1'b0;
            mosi_o = cmd[k];
            #80;
            sclk_o = 1'b1;
            rsp[k] = miso_oe_n_i ? 1'bx : miso_i;
            #80;
        end
        // released line shows the inverse so a late sample cannot pass
        mosi_o = ~cmd[0];
        #36000;
        slept = (data_ready_out_oe_n_i === 1'b0 && data_ready_out_i === 1'b0);
        ss_n_o = 1'b1;
    endtask

    task automatic pulse(input int len_ns);
        ss_n_o = 1'b0;
        #len_ns;
        ss_n_o = 1'b1;
    endtask
endmodule

// [tsspi_slider_port_tb.sv]
`timescale 1ns/100ps

module tsspi_slider_port_tb;
    logic                     clk = 1'b0;
    logic                     rst_n = 1'b0;
    logic                     burst_done = 1'b0;
    tsspi_pkg::tsspi_acq_type acq = '0;
    tsspi_pkg::tsspi_cfg_type cfg, cfg_old;
    logic                     sclk, host_ss_n, mosi, ss_n, ss_oe_n, miso, miso_oe_n;
    logic                     data_ready_out, data_ready_out_oe_n, burst_start, drift_step, slept;
    logic                     ss_pull, touch_pin, near_pin, flags_oe_n;
    logic [7:0]               r;
    int                       num_errors = 0, n_checks = 0;
    int                       n_bursts = 0, dly = 0, n_drift = 0, n_ss_low = 0;

    always #5 clk = ~clk;
    // open-drain select with pull-up
    assign ss_n = (host_ss_n === 1'b0 || ss_oe_n === 1'b0) ? 1'b0 : 1'b1;

    tsspi_slider_port #(.P_PWR_FLOAT(200), .P_WAKE_BURST(92), .P_WAKE_FLOAT(40),
        .P_DUMMY_BURST(100), .P_SS_TIMEOUT(2000), .P_FREERUN(500)) tsspi_slider_port_i (
        .clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk), .ss_n_i(ss_n), .ss_n_o(ss_pull),
        .ss_n_oe_n_o(ss_oe_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_n_o(miso_oe_n),
        .data_ready_out_o(data_ready_out), .data_ready_oe_n_o(data_ready_out_oe_n),
        .touch_flag_pin_o(touch_pin), .near_flag_pin_o(near_pin),
        .flags_oe_n_o(flags_oe_n), .burst_start_o(burst_start),
        .burst_done_i(burst_done), .acq_i(acq), .cfg_o(cfg), .drift_step_o(drift_step));

    tsspi_host_model tsspi_host_model_i (.sclk_o(sclk), .ss_n_o(host_ss_n), .mosi_o(mosi),
        .miso_i(miso), .miso_oe_n_i(miso_oe_n), .data_ready_out_i(data_ready_out), .data_ready_out_oe_n_i(data_ready_out_oe_n));

    // ****************************************************************
    // acquisition core stand-in: each burst takes 20 cycles
    // ****************************************************************
    always @(negedge clk) begin
        burst_done <= (dly == 1);
        if (drift_step === 1'b1) n_drift <= n_drift + 1;
        if (ss_oe_n === 1'b0) n_ss_low <= n_ss_low + 1;
        if (dly != 0) begin
            dly <= dly - 1;
        end else if (burst_start === 1'b1) begin
            dly <= 20;
            n_bursts <= n_bursts + 1;
        end
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic ready();
        for (int i = 0; i < 20000; i++) begin
            @(posedge clk);
            if (data_ready_out_oe_n === 1'b0 && data_ready_out === 1'b1) return;
        end
        num_errors++;
        $display("Error data ready expected 1 seen %b", data_ready_out);
        give_verdict();
    endtask

    task automatic send(input logic [7:0] c, output logic [7:0] rsp);
        ready();
        n_bursts = 0;
        n_ss_low = 0;
        tsspi_host_model_i.xfer(c, rsp, slept);
        check("sleep data ready low", 1'b1, slept);
        #200;
        check("miso released", 1'b1, miso_oe_n);
        check("data ready floats on wake", 1'b1, data_ready_out_oe_n);
        check("flags float on wake", 1'b1, flags_oe_n);
        ready();
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_powerup();
        check("data ready floats", 1'b1, data_ready_out_oe_n);
        ready();
        check("power-up bursts", 10, n_bursts);
        $display("test powerup done");
    endtask

    task automatic t_response();
        @(negedge clk) acq = 10'h002;
        send(8'h00, r);
        check("null bursts", 1, n_bursts);
        check("wake pulse cycles", tsspi_pkg::SS_PULSE_CYC, n_ss_low);
        check("select pull level", 1'b0, ss_pull);
        @(negedge clk) acq = 10'h354;
        send(8'h00, r);
        check("polarity response", 8'h02, r);
        check("touch flag pin", 1'b1, touch_pin);
        @(negedge clk) acq = 10'h001;
        send(8'h00, r);
        check("touch response", {1'b1, 7'h55}, r);
        send(8'h00, r);
        check("prox response", 8'h01, r);
        check("near flag pin", 1'b1, near_pin);
        $display("test response done");
    endtask

    task automatic t_thresh();
        send(8'h47, r);
        check("prox threshold", 6'h07, cfg.prox_thr);
        send(8'h8c, r);
        check("touch threshold", 8'h0c * 4, cfg.touch_thr);
        check("touch hysteresis", (8'h0c * 4) >> 3, cfg.touch_hyst);
        cfg_old = cfg;
        send(8'h3f, r);
        check("unknown code cfg", cfg_old, cfg);
        send(8'hc5, r);
        check("unknown code cfg", cfg_old, cfg);
        check("unknown code bursts", 1, n_bursts);
        $display("test thresholds done");
    endtask

    task automatic t_cal();
        send(8'h02, r);
        check("end cal bursts", 20, n_bursts);
        check("end cal enabled", 1'b1, cfg.end_cal_en);
        send(8'h01, r);
        check("cal bursts", 10, n_bursts);
        check("end cal cleared", 1'b0, cfg.end_cal_en);
        $display("test calibrate done");
    endtask

    task automatic t_drift();
        @(negedge clk) acq = 10'h000;
        n_drift = 0;
        repeat (10) send(8'h03, r);
        check("drift steps", 1, n_drift);
        $display("test drift done");
    endtask

    task automatic t_dummy_free();
        ready();
        n_bursts = 0;
        tsspi_host_model_i.pulse(11000);
        #300;
        check("data ready after pulse", 1'b0, data_ready_out);
        check("burst held off", 0, n_bursts);
        ready();
        check("dummy bursts", 1, n_bursts);
        n_bursts = 0;
        repeat (700) @(posedge clk);
        check("free-run burst", 1'b1, n_bursts != 0);
        $display("test dummy and free-run done");
    endtask

    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        t_powerup();
        t_response();
        t_thresh();
        t_cal();
        t_drift();
        t_dummy_free();
        give_verdict();
    end
endmodule
